// *** verilog/fesp_map.svh ***
// constants of the flash erase host controller
`ifndef FESP_MAP_SVH
`define FESP_MAP_SVH
`define FESP_UNLOCK_ADDR1 18'h05555
`define FESP_UNLOCK_ADDR2 18'h02AAA
`define FESP_UNLOCK_DATA1 8'hAA
`define FESP_UNLOCK_DATA2 8'h55
`define FESP_SETUP_DATA 8'h80
`define FESP_CHIP_ERASE_DATA 8'h10
`define FESP_SECTOR_ERASE_DATA 8'h30
`define FESP_IDENT_DATA 8'h90
`define FESP_RESET_DATA 8'hF0
`define FESP_MAKER_ADDR 18'h00000
`define FESP_PART_ADDR 18'h00001
`define FESP_POLL_BIT 7
`define FESP_TOGGLE_BIT 6
`define FESP_GLITCH_NS 15
`define FESP_CLK_NS 100
// strobe low time: at least the glitch filter, whole cycles, never under one
`define FESP_STROBE_CYC ((`FESP_GLITCH_NS + `FESP_CLK_NS - 1) / `FESP_CLK_NS)
`define FESP_CNT_W 3
`endif

// *** verilog/fesp_pkg.sv ***
// types of the flash erase host controller
package fesp_pkg;
  typedef enum logic [1:0] {
    FESP_OP_CHIP = 2'h0,
    FESP_OP_SECTOR = 2'h1,
    FESP_OP_IDENT = 2'h2,
    FESP_OP_RESET = 2'h3
  } fesp_op_t;
  typedef enum logic [1:0] {
    FESP_BUS_IDLE = 2'h0,
    FESP_BUS_SETUP = 2'h1,
    FESP_BUS_STROBE = 2'h3,
    FESP_BUS_HOLD = 2'h2
  } fesp_bus_t;
endpackage : fesp_pkg

// *** verilog/fesp_bus_if.sv ***
// bus-cycle request and answer between sequencer and cycle engine
`timescale 1ns/100ps
interface fesp_bus_if;
  logic req;
  logic wr;
  logic [17:0] addr;
  logic [7:0] wdata;
  logic done;
  logic [7:0] rdata;
  modport seq (output req, output wr, output addr, output wdata, input done, input rdata);
  modport eng (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface : fesp_bus_if

// *** verilog/fesp_cycle.sv ***
// one flash bus cycle, write or read, on the pins
`timescale 1ns/100ps
`include "fesp_map.svh"
module fesp_cycle
  import fesp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  fesp_bus_if.eng bus,
  input wire logic [7:0] i_dq,
  output logic o_ce_n,
  output logic o_we_n,
  output logic o_oe_n,
  output logic [17:0] o_addr,
  output logic [7:0] o_dq,
  output logic o_dq_oe
);
  fesp_bus_t st_q, st_d;
  logic [`FESP_CNT_W-1:0] cnt_q, cnt_d;
  logic wr_q, wr_d;
  logic ce_n_q, ce_n_d, we_n_q, we_n_d, oe_n_q, oe_n_d, dq_oe_q, dq_oe_d, done_q, done_d;
  logic [17:0] addr_q, addr_d;
  logic [7:0] dq_q, dq_d, rd_q, rd_d;

  // next-state of the cycle engine
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    wr_d = wr_q;
    ce_n_d = ce_n_q;
    we_n_d = we_n_q;
    oe_n_d = oe_n_q;
    dq_oe_d = dq_oe_q;
    addr_d = addr_q;
    dq_d = dq_q;
    rd_d = rd_q;
    done_d = 1'b0;
    unique case (st_q)
      FESP_BUS_IDLE: begin
        if (bus.req) begin
          // address set before either strobe falls, oe high for writes
          st_d = FESP_BUS_SETUP;
          wr_d = bus.wr;
          addr_d = bus.addr;
          dq_d = bus.wdata;
          dq_oe_d = bus.wr;
          oe_n_d = 1'b1;
        end
      end
      FESP_BUS_SETUP: begin
        st_d = FESP_BUS_STROBE;
        ce_n_d = 1'b0;
        we_n_d = !wr_q;
        oe_n_d = wr_q;
        cnt_d = `FESP_CNT_W'(`FESP_STROBE_CYC);
      end
      FESP_BUS_STROBE: begin
        // strobes held low longer than the glitch filter
        if (cnt_q > `FESP_CNT_W'(1)) begin
          cnt_d = cnt_q - `FESP_CNT_W'(1);
        end else begin
          st_d = FESP_BUS_HOLD;
          we_n_d = 1'b1;
          ce_n_d = 1'b1;
          oe_n_d = 1'b1;
          rd_d = i_dq;
        end
      end
      FESP_BUS_HOLD: begin
        // data held one cycle past the rising strobe
        st_d = FESP_BUS_IDLE;
        dq_oe_d = 1'b0;
        done_d = 1'b1;
      end
    endcase
  end

  // register the cycle engine
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= FESP_BUS_IDLE;
      cnt_q <= '0;
      wr_q <= 1'b0;
      ce_n_q <= 1'b1;
      we_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      dq_oe_q <= 1'b0;
      addr_q <= '0;
      dq_q <= '0;
      rd_q <= '0;
      done_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      wr_q <= wr_d;
      ce_n_q <= ce_n_d;
      we_n_q <= we_n_d;
      oe_n_q <= oe_n_d;
      dq_oe_q <= dq_oe_d;
      addr_q <= addr_d;
      dq_q <= dq_d;
      rd_q <= rd_d;
      done_q <= done_d;
    end
  end

  assign o_ce_n = ce_n_q;
  assign o_we_n = we_n_q;
  assign o_oe_n = oe_n_q;
  assign o_addr = addr_q;
  assign o_dq = dq_q;
  assign o_dq_oe = dq_oe_q;
  assign bus.done = done_q;
  assign bus.rdata = rd_q;
endmodule : fesp_cycle

// *** verilog/fesp_host.sv ***
// host sequencer for erase, identification and status polling of the flash
`timescale 1ns/100ps
`include "fesp_map.svh"
// Notes on behaviour
// - chip erase is six writes: two unlocks, set-up, two unlocks, command
// - chip erase pairs 5555/AA 2AAA/55 5555/80 5555/AA 2AAA/55 5555/10
// - sector erase is six writes, the sixth carries the sector address
// - sector erase as chip erase, sixth write 30 at a sector address
// - reissue an interrupted erase only after device is back in array read; the host takes a new start whenever idle with supply good, unchecked
// - two unlocks plus identification command enter identification mode
// - host polls the status bit at an address of the operation
// - writes need chip-select and write strobe low, output strobe high
module fesp_host
  import fesp_pkg::*;
(
  input wire logic I_CORE_CLK,
  input wire logic I_RST_N,
  input wire logic I_START,
  input wire fesp_op_t I_OP,
  input wire logic [17:0] I_SECTOR_ADDR,
  input wire logic I_SUPPLY_OK,
  input wire logic [7:0] I_DQ,
  output logic O_BUSY,
  output logic O_DONE,
  output logic O_ERROR,
  output logic [7:0] O_MAKER_CODE,
  output logic [7:0] O_PART_CODE,
  output logic O_CE_N,
  output logic O_WE_N,
  output logic O_OE_N,
  output logic [17:0] O_ADDR,
  output logic [7:0] O_DQ,
  output logic O_DQ_OE
);
  typedef enum logic [2:0] {
    FESP_S_IDLE = 3'h0,
    FESP_S_CMD = 3'h1,
    FESP_S_WAITW = 3'h3,
    FESP_S_POLL = 3'h2,
    FESP_S_WAITR = 3'h6,
    FESP_S_FINAL = 3'h7,
    FESP_S_END = 3'h5
  } fesp_seq_t;

  fesp_bus_if bus ();
  fesp_seq_t st_q, st_d;
  fesp_op_t op_q, op_d;
  logic [2:0] step_q, step_d;
  logic [17:0] sect_q, sect_d;
  logic [1:0] rd_idx_q, rd_idx_d;
  logic have_q, have_d;
  logic last_tog_q, last_tog_d;
  logic fin_q, fin_d;
  logic busy_q, busy_d, done_q, done_d, err_q, err_d;
  logic [7:0] maker_q, maker_d, part_q, part_d;
  logic [17:0] cmd_addr;
  logic [7:0] cmd_data;
  logic [2:0] cmd_len;

  fesp_cycle u_cycle (
    .i_clk(I_CORE_CLK),
    .i_rst_n(I_RST_N),
    .bus(bus.eng),
    .i_dq(I_DQ),
    .o_ce_n(O_CE_N),
    .o_we_n(O_WE_N),
    .o_oe_n(O_OE_N),
    .o_addr(O_ADDR),
    .o_dq(O_DQ),
    .o_dq_oe(O_DQ_OE)
  );

  // command table: address and data of each write of the chosen sequence
  always_comb begin
    cmd_addr = `FESP_UNLOCK_ADDR1;
    cmd_data = `FESP_UNLOCK_DATA1;
    cmd_len = 3'h6;
    if (op_q == FESP_OP_IDENT) begin
      cmd_len = 3'h3;
    end else if (op_q == FESP_OP_RESET) begin
      cmd_len = 3'h1;
    end
    unique case (step_q)
      3'h0: begin
        if (op_q == FESP_OP_RESET) begin
          cmd_data = `FESP_RESET_DATA;
        end
      end
      3'h1, 3'h4: begin
        cmd_addr = `FESP_UNLOCK_ADDR2;
        cmd_data = `FESP_UNLOCK_DATA2;
      end
      3'h2: begin
        cmd_data = (op_q == FESP_OP_IDENT) ? `FESP_IDENT_DATA : `FESP_SETUP_DATA;
      end
      3'h3: begin
        cmd_data = `FESP_UNLOCK_DATA1;
      end
      default: begin
        if (op_q == FESP_OP_SECTOR) begin
          cmd_addr = sect_q;
          cmd_data = `FESP_SECTOR_ERASE_DATA;
        end else begin
          cmd_data = `FESP_CHIP_ERASE_DATA;
        end
      end
    endcase
  end

  // sequencer next state
  always_comb begin
    st_d = st_q;
    op_d = op_q;
    step_d = step_q;
    sect_d = sect_q;
    rd_idx_d = rd_idx_q;
    have_d = have_q;
    last_tog_d = last_tog_q;
    fin_d = fin_q;
    busy_d = busy_q;
    done_d = 1'b0;
    err_d = err_q;
    maker_d = maker_q;
    part_d = part_q;
    bus.req = 1'b0;
    bus.wr = 1'b1;
    bus.addr = cmd_addr;
    bus.wdata = cmd_data;
    unique case (st_q)
      FESP_S_IDLE: begin
        // new work taken only while idle, so an erase is never overlapped
        if (I_START && I_SUPPLY_OK) begin
          st_d = FESP_S_CMD;
          op_d = I_OP;
          sect_d = I_SECTOR_ADDR;
          step_d = 3'h0;
          busy_d = 1'b1;
          err_d = 1'b0;
        end
      end
      FESP_S_CMD: begin
        bus.req = 1'b1;
        st_d = FESP_S_WAITW;
      end
      FESP_S_WAITW: begin
        if (bus.done) begin
          if (!I_SUPPLY_OK) begin
            // supply lost mid-sequence: device has reset, report failure
            st_d = FESP_S_END;
            err_d = 1'b1;
          end else if (step_q == cmd_len - 3'h1) begin
            step_d = 3'h0;
            have_d = 1'b0;
            rd_idx_d = 2'h0;
            st_d = (op_q == FESP_OP_RESET) ? FESP_S_END : FESP_S_POLL;
          end else begin
            step_d = step_q + 3'h1;
            st_d = FESP_S_CMD;
          end
        end
      end
      FESP_S_POLL: begin
        bus.req = 1'b1;
        bus.wr = 1'b0;
        if (op_q == FESP_OP_IDENT) begin
          bus.addr = (rd_idx_q == 2'h0) ? `FESP_MAKER_ADDR : `FESP_PART_ADDR;
        end else begin
          bus.addr = (op_q == FESP_OP_SECTOR) ? sect_q : `FESP_MAKER_ADDR;
        end
        st_d = FESP_S_WAITR;
      end
      FESP_S_WAITR: begin
        if (bus.done) begin
          st_d = FESP_S_POLL;
          if (fin_q) begin
            // the later read is trusted; erase ends with polling bit high
            fin_d = 1'b0;
            err_d = !bus.rdata[`FESP_POLL_BIT];
            st_d = FESP_S_END;
          end else if (op_q == FESP_OP_IDENT) begin
            if (rd_idx_q == 2'h0) begin
              maker_d = bus.rdata;
              rd_idx_d = 2'h1;
            end else begin
              part_d = bus.rdata;
              // leave identification mode by the reset command
              op_d = FESP_OP_RESET;
              st_d = FESP_S_CMD;
            end
          end else if (!I_SUPPLY_OK) begin
            st_d = FESP_S_END;
            err_d = 1'b1;
          end else if (have_q && (bus.rdata[`FESP_TOGGLE_BIT] == last_tog_q)) begin
            // toggle stopped: one more read confirms the polling bit
            st_d = FESP_S_FINAL;
          end else begin
            have_d = 1'b1;
            last_tog_d = bus.rdata[`FESP_TOGGLE_BIT];
          end
        end
      end
      FESP_S_FINAL: begin
        // confirming read requested for one cycle only, so no extra bus cycle follows
        bus.req = 1'b1;
        bus.wr = 1'b0;
        bus.addr = (op_q == FESP_OP_SECTOR) ? sect_q : `FESP_MAKER_ADDR;
        fin_d = 1'b1;
        st_d = FESP_S_WAITR;
      end
      FESP_S_END: begin
        st_d = FESP_S_IDLE;
        busy_d = 1'b0;
        done_d = 1'b1;
      end
      default: begin
        st_d = FESP_S_IDLE;
      end
    endcase
  end

  // register sequencer state
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st_q <= FESP_S_IDLE;
      op_q <= FESP_OP_CHIP;
      step_q <= 3'h0;
      sect_q <= '0;
      rd_idx_q <= 2'h0;
      have_q <= 1'b0;
      last_tog_q <= 1'b0;
      fin_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      err_q <= 1'b0;
      maker_q <= 8'h00;
      part_q <= 8'h00;
    end else begin
      st_q <= st_d;
      op_q <= op_d;
      step_q <= step_d;
      sect_q <= sect_d;
      rd_idx_q <= rd_idx_d;
      have_q <= have_d;
      last_tog_q <= last_tog_d;
      fin_q <= fin_d;
      busy_q <= busy_d;
      done_q <= done_d;
      err_q <= err_d;
      maker_q <= maker_d;
      part_q <= part_d;
    end
  end

  assign O_BUSY = busy_q;
  assign O_DONE = done_q;
  assign O_ERROR = err_q;
  assign O_MAKER_CODE = maker_q;
  assign O_PART_CODE = part_q;
endmodule : fesp_host

// *** testbench/fesp_host_properties.sv ***
// pin-level assertions of the flash erase host controller
`timescale 1ns/100ps
module fesp_host_chk (
  input wire logic I_CORE_CLK,
  input wire logic I_RST_N,
  input wire logic I_START,
  input wire logic I_SUPPLY_OK,
  input wire logic O_BUSY,
  input wire logic O_DONE,
  input wire logic O_CE_N,
  input wire logic O_WE_N,
  input wire logic O_OE_N,
  input wire logic [17:0] O_ADDR,
  input wire logic [7:0] O_DQ,
  input wire logic O_DQ_OE
);
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);
  // request taken, busy follows on the next edge
  a_start_busy: assert property (I_START && !O_BUSY && I_SUPPLY_OK |=> O_BUSY) else $error("start lost");
  a_refuse_start: assert property (I_START && !O_BUSY && !I_SUPPLY_OK |=> !O_BUSY) else $error("low supply start");
  a_done_pulse: assert property (O_DONE |=> !O_DONE) else $error("done too long");
  a_done_idle: assert property (O_DONE |-> !O_BUSY && $past(O_BUSY)) else $error("busy after done");
  // one write strobe, address set before it and data held past it
  a_strobe_one: assert property ($fell(O_WE_N) |=> O_WE_N && O_CE_N) else $error("strobe width");
  a_addr_held: assert property ($fell(O_WE_N) |-> $stable(O_ADDR) ##1 $stable(O_DQ) && O_DQ_OE) else $error("setup");
  // write and read qualifiers on the pins
  a_write_gate: assert property (!O_WE_N |-> !O_CE_N && O_OE_N && O_DQ_OE) else $error("write gate");
  a_read_gate: assert property (!O_OE_N |-> !O_CE_N && O_WE_N && !O_DQ_OE) else $error("read gate");
  a_unlock_data: assert property (!O_WE_N && O_ADDR == 18'h02AAA |-> O_DQ == 8'h55) else $error("unlock data");
endmodule : fesp_host_chk
bind fesp_host fesp_host_chk u_chk (.I_CORE_CLK(I_CORE_CLK), .I_RST_N(I_RST_N), .I_START(I_START),
  .I_SUPPLY_OK(I_SUPPLY_OK), .O_BUSY(O_BUSY), .O_DONE(O_DONE), .O_CE_N(O_CE_N), .O_WE_N(O_WE_N),
  .O_OE_N(O_OE_N), .O_ADDR(O_ADDR), .O_DQ(O_DQ), .O_DQ_OE(O_DQ_OE));

// *** testbench/fesp_flash_model.sv ***
// behavioural flash device on the host controller's pins
`timescale 1ns/100ps
module fesp_flash_model #(
  parameter int BUSY_READS = 6,
  parameter logic [7:0] MAKER = 8'h5A, // arbitrary value
  parameter logic [7:0] PART = 8'hC3 // arbitrary value
) (
  input wire logic i_ce_n,
  input wire logic i_we_n,
  input wire logic i_oe_n,
  input wire logic [17:0] i_addr,
  input wire logic [7:0] i_dq,
  input wire logic i_supply_ok,
  input wire logic i_fail,
  output logic [7:0] o_dq
);
  wire wr_n = i_ce_n | i_we_n;
  wire rd_n = i_ce_n | i_oe_n;
  int step = 0;
  int busy_left = 0;
  logic ident = 1'b0;
  logic tog = 1'b0;
  logic pwr_inh = 1'b0;
  logic [17:0] a_q = 18'h00000;
  logic [7:0] rv = 8'h00;
  // released pins show the inverse of the last value
  assign o_dq = rd_n ? ~rv : rv;
  always @(negedge wr_n) a_q = i_addr;
  // strobes already low while the supply comes up: that write is not taken
  always @(posedge i_supply_ok) pwr_inh = !wr_n;
  // lockout drops the command state and any erase
  always @(negedge i_supply_ok) begin
    step = 0;
    busy_left = 0;
    ident = 1'b0;
  end
  // commands decoded at the earlier rising edge, ignored while erasing
  always @(posedge wr_n) begin
    if (pwr_inh) begin
      pwr_inh = 1'b0;
    end else if (i_oe_n === 1'b1 && i_supply_ok && busy_left == 0) begin
      if (i_dq == 8'hF0) begin
        step = 0;
        ident = 1'b0;
      end else if (step == 2 && a_q == 18'h05555 && i_dq == 8'h90) begin
        step = 0;
        ident = 1'b1;
      end else if (step == 5 && (a_q == 18'h05555 && i_dq == 8'h10 || i_dq == 8'h30)) begin
        step = 0;
        busy_left = BUSY_READS;
      end else if (step < 5 && a_q == (step[0] ? 18'h02AAA : 18'h05555)
          && i_dq == (step == 2 ? 8'h80 : (step[0] ? 8'h55 : 8'hAA))) begin
        step++;
      end else begin
        step = (a_q == 18'h05555 && i_dq == 8'hAA) ? 1 : 0;
        ident = 1'b0;
      end
    end
  end
  // status while erasing, codes in identification, else array data
  always @(negedge rd_n) begin
    if (busy_left > 0) begin
      busy_left--;
      tog = ~tog;
      rv = {1'b0, tog, 6'h00};
    end else if (ident) begin
      rv = (i_addr == 18'h00001) ? PART : (i_addr[17:4] == 0 && i_addr[1:0] == 0) ? MAKER : 8'h00;
    end else begin
      rv = i_fail ? 8'h7F : 8'hFF;
    end
  end
endmodule : fesp_flash_model

// *** testbench/fesp_host_tb.sv ***
// self-checking bench of the flash erase host controller
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module fesp_host_tb;
  import fesp_pkg::*;
  localparam logic [7:0] MAKER = 8'h5A; // arbitrary value
  localparam logic [7:0] PART = 8'hC3; // arbitrary value
  localparam logic [25:0] U1 = 26'h05555AA;
  localparam logic [25:0] U2 = 26'h02AAA55;
  localparam logic [25:0] SU = 26'h0555580;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  fesp_op_t op = FESP_OP_CHIP;
  logic [17:0] sa = 18'h00000;
  logic sup = 1'b1;
  logic fail = 1'b0;
  logic [7:0] dq, wd, maker, part;
  logic busy, done, err, ce_n, we_n, oe_n, dq_oe;
  logic [17:0] addr;
  logic [25:0] log_q[$];
  int n_errors = 0;
  int n_checks = 0;
  always #50 clk = ~clk;
  fesp_host uut (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_START(start), .I_OP(op), .I_SECTOR_ADDR(sa),
    .I_SUPPLY_OK(sup), .I_DQ(dq), .O_BUSY(busy), .O_DONE(done), .O_ERROR(err), .O_MAKER_CODE(maker),
    .O_PART_CODE(part), .O_CE_N(ce_n), .O_WE_N(we_n), .O_OE_N(oe_n), .O_ADDR(addr), .O_DQ(wd), .O_DQ_OE(dq_oe));
  fesp_flash_model #(.MAKER(MAKER), .PART(PART)) u_flash (.i_ce_n(ce_n), .i_we_n(we_n), .i_oe_n(oe_n),
    .i_addr(addr), .i_dq(wd), .i_supply_ok(sup), .i_fail(fail), .o_dq(dq));
  // log every completed write on the pins
  always @(posedge (ce_n | we_n)) log_q.push_back({addr, wd});
  task automatic go(input fesp_op_t o, input logic [17:0] a);
    @(posedge clk);
    log_q.delete();
    op <= o;
    sa <= a;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
  endtask : go
  task automatic wait_done();
    int k;
    k = 0;
    while (done !== 1'b1 && k < 400) begin
      @(negedge clk);
      k++;
    end
    `CHK("done", 1'b1, done)
  endtask : wait_done
  task automatic chk_log(input logic [25:0] e[$]);
    `CHK("writes", e.size(), log_q.size())
    foreach (e[i]) `CHK("write", e[i], log_q[i])
  endtask : chk_log
  task automatic t_erase(input fesp_op_t o, input logic [17:0] a, input logic [25:0] last, input logic f);
    fail <= f;
    go(o, a);
    wait_done();
    chk_log('{U1, U2, SU, U1, U2, last});
    `CHK("error", f, err)
    $display("test erase op %0d done", o);
  endtask : t_erase
  task automatic t_ident();
    go(FESP_OP_IDENT, 18'h00000);
    wait_done();
    chk_log('{U1, U2, 26'h0555590, 26'h05555F0});
    `CHK("maker", MAKER, maker)
    `CHK("part", PART, part)
    $display("test ident done");
  endtask : t_ident
  task automatic t_supply();
    @(posedge clk);
    sup <= 1'b0;
    go(FESP_OP_CHIP, 18'h00000);
    repeat (5) @(negedge clk);
    `CHK("refused", 1'b0, busy)
    @(posedge clk);
    sup <= 1'b1;
    go(FESP_OP_CHIP, 18'h00000);
    repeat (40) @(posedge clk);
    sup <= 1'b0;
    wait_done();
    `CHK("abort error", 1'b1, err)
    @(posedge clk);
    sup <= 1'b1;
    t_erase(FESP_OP_CHIP, 18'h00000, 26'h0555510, 1'b0);
    $display("test supply done");
  endtask : t_supply
  task automatic t_reset();
    go(FESP_OP_CHIP, 18'h00000);
    repeat (12) @(posedge clk);
    rst_n <= 1'b0;
    @(negedge clk);
    `CHK("busy in reset", 1'b0, busy)
    `CHK("ce in reset", 1'b1, ce_n)
    @(posedge clk);
    rst_n <= 1'b1;
    go(FESP_OP_RESET, 18'h00000);
    wait_done();
    `CHK("reset cmd", 8'hF0, log_q[0][7:0])
    $display("test reset done");
  endtask : t_reset
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done
  // watchdog against a hang
  initial begin
    repeat (4000) @(posedge clk);
    n_errors++;
    test_done();
  end
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_erase(FESP_OP_CHIP, 18'h00000, 26'h0555510, 1'b0);
    t_erase(FESP_OP_SECTOR, 18'h1C000, 26'h1C00030, 1'b0);
    t_erase(FESP_OP_SECTOR, 18'h04000, 26'h0400030, 1'b1);
    t_ident();
    t_supply();
    t_reset();
    t_ident();
    test_done();
  end
endmodule : fesp_host_tb
